// [hdl/emp_params.svh]
// Constants for the external memory port strobe block
`ifndef EMP_PARAMS_SVH
`define EMP_PARAMS_SVH
`define EMP_ADDR_W      24
`define EMP_DATA_W      32
`define EMP_NBANK       2
`define EMP_BANK_LSB    22
`define EMP_STROBE_MIN  2
`define EMP_CNT_W       5
`define EMP_RST_STROBE  1'b1
`define EMP_RST_OE      1'b0
`define EMP_LANE8_MASK  32'h0000_00FF
`define EMP_LANE16_MASK 32'h0000_FFFF
`endif

// [hdl/emp_pkg.sv]
// Types for the external memory port strobe block
package emp_pkg;
  typedef enum logic [3:0] {
    EMP_IDLE   = 4'h1,
    EMP_SETUP  = 4'h2,
    EMP_STROBE = 4'h4,
    EMP_END    = 4'h8
  } emp_state_t;

  typedef enum logic [0:0] {
    EMP_W8  = 1'h0,
    EMP_W16 = 1'h1
  } emp_width_t;
endpackage

// [hdl/emp_dec_if.sv]
// Carrier between the port sequencer and the bank decoder
interface emp_dec_if #(
  parameter int AW = 24,
  parameter int NB = 2
);
  logic [AW-1:0] addr;
  logic [NB-1:0] sel_n;
  modport req (output addr, input sel_n);
  modport dec (input addr, output sel_n);
endinterface

// [hdl/emp_bank_dec.sv]
// Bank chip-select decoder from the external address
module emp_bank_dec #(
  parameter int AW  = 24,
  parameter int NB  = 2,
  parameter int LSB = 22
) (
  emp_dec_if.dec dif
);
  localparam int BW = (NB > 1) ? $clog2(NB) : 1;

  // One-hot active-low select, all high when out of range
  function automatic logic [NB-1:0] bank_dec(input logic [BW-1:0] idx);
    logic [NB-1:0] sel;
    sel = '1;
    for (int i = 0; i < NB; i++) begin
      if (idx == BW'(i)) begin
        sel[i] = 1'b0;
      end
    end
    return sel;
  endfunction

  wire logic [BW-1:0] bank_idx;

  // Bank index sits in the address bits from LSB upward
  assign bank_idx  = dif.addr[LSB +: BW];
  assign dif.sel_n = bank_dec(bank_idx);
endmodule

// [hdl/emp_port.sv]
// External memory port: address, data, strobes and bank selects
`include "emp_params.svh"
module emp_port #(
  parameter int AW         = `EMP_ADDR_W,
  parameter int DW         = `EMP_DATA_W,
  parameter int NBANK      = `EMP_NBANK,
  parameter int BANK_LSB   = `EMP_BANK_LSB,
  parameter int STROBE_MIN = `EMP_STROBE_MIN
) (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  req_valid,
  input  wire logic                  req_we,
  input  wire logic                  req_sdram,
  input  wire logic                  req_cond_true,
  input  wire emp_pkg::emp_width_t   req_width,
  input  wire logic [AW-1:0]         req_addr,
  input  wire logic [DW-1:0]         req_wdata,
  input  wire logic                  flags_mode,
  output logic                       req_ready,
  output logic                       done,
  output logic [DW-1:0]              rdata,
  input  wire logic                  ack_i,
  output logic [AW-1:0]              addr_o,
  output logic                       addr_oe,
  input  wire logic [DW-1:0]         data_i,
  output logic [DW-1:0]              data_o,
  output logic                       data_oe,
  output logic                       rd_n,
  output logic                       wr_n,
  output logic                       sdram_row_strobe_n,
  output logic [NBANK-1:0]           bank_select_n
);
  //----------------------------------------------------------------
  // Elaboration checks
  //----------------------------------------------------------------
  if (NBANK < 1 || NBANK > 4 || STROBE_MIN < 1 || STROBE_MIN > 31 ||
      BANK_LSB + 2 > AW || DW < 16) begin : g_chk
    $error("emp_port: unsupported parameter values");
  end

  //----------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------
  localparam logic [`EMP_CNT_W-1:0] CNT_LOAD = `EMP_CNT_W'(STROBE_MIN - 1);

  emp_pkg::emp_state_t      state_ff;
  logic [AW-1:0]            addr_ff;
  logic                     addr_oe_ff;
  logic [DW-1:0]            data_o_ff;
  logic                     data_oe_ff;
  logic                     rd_n_ff;
  logic                     wr_n_ff;
  logic                     ras_n_ff;
  logic [NBANK-1:0]         bsel_n_ff;
  logic [`EMP_CNT_W-1:0]    cnt_ff;
  logic                     done_ff;
  logic                     ready_ff;
  logic [DW-1:0]            rdata_ff;
  logic                     op_we_ff;
  logic                     op_go_ff;
  logic [DW-1:0]            mask_ff;
  logic                     ack_meta_ff;
  logic                     ack_sync_ff;
  logic [DW-1:0]            din_meta_ff;
  logic [DW-1:0]            din_sync_ff;

  emp_dec_if #(.AW(AW), .NB(NBANK)) dif ();

  //----------------------------------------------------------------
  // Bank decode
  //----------------------------------------------------------------
  assign dif.addr = req_addr;

  emp_bank_dec #(.AW(AW), .NB(NBANK), .LSB(BANK_LSB)) u_dec (
    .dif (dif)
  );

  //----------------------------------------------------------------
  // Decoding of the sequencer
  //----------------------------------------------------------------
  wire logic            is_idle;
  wire logic            is_setup;
  wire logic            is_strobe;
  wire logic            is_end;
  wire logic            take;
  wire logic            cnt_zero;
  wire logic            finish;
  wire logic [DW-1:0]   lane_mask;
  wire logic            rd_on;
  wire logic            wr_on;

  assign is_idle   = (state_ff == emp_pkg::EMP_IDLE);
  assign is_setup  = (state_ff == emp_pkg::EMP_SETUP);
  assign is_strobe = (state_ff == emp_pkg::EMP_STROBE);
  assign is_end    = (state_ff == emp_pkg::EMP_END);
  assign take      = is_idle && req_valid;
  assign cnt_zero  = (cnt_ff == '0);
  assign finish    = is_strobe && cnt_zero && ack_sync_ff;
  assign lane_mask = (req_width == emp_pkg::EMP_W8) ? DW'(`EMP_LANE8_MASK)
                                                    : DW'(`EMP_LANE16_MASK);
  // Strobe requests, held off in flag mode
  assign rd_on = op_go_ff && !op_we_ff && !flags_mode;
  assign wr_on = op_go_ff && op_we_ff && !flags_mode;

  //----------------------------------------------------------------
  // Pin input synchronisers
  //----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_meta_ff <= 1'b1;
      ack_sync_ff <= 1'b1;
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else begin
      ack_meta_ff <= ack_i;
      ack_sync_ff <= ack_meta_ff;
      din_meta_ff <= data_i;
      din_sync_ff <= din_meta_ff;
    end
  end

  //----------------------------------------------------------------
  // State sequencer
  //----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= emp_pkg::EMP_IDLE;
      cnt_ff   <= '0;
    end else begin
      case (state_ff)
        emp_pkg::EMP_IDLE: begin
          if (req_valid) begin
            state_ff <= emp_pkg::EMP_SETUP;
          end
        end
        emp_pkg::EMP_SETUP: begin
          cnt_ff   <= CNT_LOAD;
          // False condition or flag mode: no read or write strobe, straight to end
          state_ff <= (rd_on || wr_on) ? emp_pkg::EMP_STROBE : emp_pkg::EMP_END;
        end
        emp_pkg::EMP_STROBE: begin
          if (!cnt_zero) begin
            cnt_ff <= cnt_ff - `EMP_CNT_W'(1);
          end else if (ack_sync_ff) begin
            state_ff <= emp_pkg::EMP_END;
          end
        end
        emp_pkg::EMP_END: begin
          state_ff <= emp_pkg::EMP_IDLE;
        end
        default: begin
          state_ff <= emp_pkg::EMP_IDLE;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // Address, data and select pins
  //----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff    <= '0;
      addr_oe_ff <= `EMP_RST_OE;
      data_o_ff  <= '0;
      data_oe_ff <= `EMP_RST_OE;
      bsel_n_ff  <= '1;
      op_we_ff   <= 1'b0;
      op_go_ff   <= 1'b0;
      mask_ff    <= '0;
    end else if (take) begin
      addr_ff    <= req_addr;
      addr_oe_ff <= 1'b1;
      data_o_ff  <= req_wdata & lane_mask;
      data_oe_ff <= req_we && req_cond_true;
      bsel_n_ff  <= dif.sel_n;
      op_we_ff   <= req_we;
      op_go_ff   <= req_cond_true;
      mask_ff    <= lane_mask;
    end else if (is_end) begin
      addr_oe_ff <= 1'b0;
      data_oe_ff <= 1'b0;
      bsel_n_ff  <= '1;
    end
  end

  //----------------------------------------------------------------
  // Strobes, completion and read data
  //----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_n_ff  <= `EMP_RST_STROBE;
      wr_n_ff  <= `EMP_RST_STROBE;
      ras_n_ff <= `EMP_RST_STROBE;
      done_ff  <= 1'b0;
      ready_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ras_n_ff <= !(take && req_sdram);
      rd_n_ff  <= !((is_setup || (is_strobe && !finish)) && rd_on);
      wr_n_ff  <= !((is_setup || (is_strobe && !finish)) && wr_on);
      done_ff  <= is_end;
      ready_ff <= (is_idle && !req_valid) || is_end;
      // Word taken a cycle after release, so the synchroniser holds a strobed sample
      if (is_end && rd_on) begin
        rdata_ff <= din_sync_ff & mask_ff;
      end
    end
  end

  // Outputs straight from flip-flops
  assign req_ready          = ready_ff;
  assign done               = done_ff;
  assign rdata              = rdata_ff;
  assign addr_o             = addr_ff;
  assign addr_oe            = addr_oe_ff;
  assign data_o             = data_o_ff;
  assign data_oe            = data_oe_ff;
  assign rd_n               = rd_n_ff;
  assign wr_n               = wr_n_ff;
  assign sdram_row_strobe_n = ras_n_ff;
  assign bank_select_n      = bsel_n_ff;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  ack_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (is_strobe && cnt_zero && !ack_sync_ff) |=> (is_strobe && (!rd_n_ff || !wr_n_ff)))
    else $error("access completed while acknowledge low");

  ack_finish_a: assert property (@(posedge mclk) disable iff (!arst_n)
    finish |=> (is_end && rd_n_ff && wr_n_ff) ##1 (is_idle && done_ff))
    else $error("access did not complete after acknowledge");

  read_strobe_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (is_setup && rd_on) |=> (!rd_n_ff && wr_n_ff)[*2])
    else $error("read strobe not asserted for read");

  write_strobe_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (is_setup && wr_on) |=> (!wr_n_ff && rd_n_ff)[*2])
    else $error("write strobe not asserted for write");

  flag_strobes_a: assert property (@(posedge mclk) disable iff (!arst_n)
    flags_mode |=> (rd_n_ff && wr_n_ff))
    else $error("strobe asserted in flag mode");

  row_strobe_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (take && req_sdram) |=> !sdram_row_strobe_n ##1 sdram_row_strobe_n)
    else $error("row strobe pulse wrong");

  bus_float_a: assert property (@(posedge mclk) disable iff (!arst_n)
    is_idle |-> (!addr_oe_ff && !data_oe_ff && rd_n_ff && wr_n_ff))
    else $error("bus driven while idle");

  select_addr_a: assert property (@(posedge mclk) disable iff (!arst_n)
    take |=> (addr_oe_ff && addr_o == $past(req_addr) &&
              bank_select_n == $past(dif.sel_n)))
    else $error("bank select not timed with address");

  select_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
    is_idle |-> (&bsel_n_ff))
    else $error("bank select active with no access");
endmodule

// [verif/emp_mem_model.sv]
// Behavioural external memory answering the port's strobes
module emp_mem_model (
  input  wire logic        mclk,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [23:0] addr_o,
  input  wire logic        addr_oe,
  input  wire logic [31:0] data_o,
  input  wire logic        data_oe,
  input  wire logic [3:0]  wait_cycles,
  output logic             ack_i,
  output logic [31:0]      data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [16];
  logic [31:0] last_ff;
  logic [3:0]  cnt_ff;
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    last_ff = 32'h0;
    cnt_ff = 4'h0;
  end
  // Holds off completion for the first wait_cycles cycles of each access
  // Low from the address phase on, so the port's synchroniser sees it in time
  assign ack_i = !(addr_oe && (cnt_ff < wait_cycles));
  // Stored word while read strobe low, inverted leftovers once released
  assign data_i = rd_n ? ~last_ff : mem[addr_o[3:0]];
  // Address-enable cycle count, last read value and write capture
  always @(posedge mclk) begin
    cnt_ff <= addr_oe ? cnt_ff + 4'h1 : 4'h0;
    if (!rd_n) last_ff <= data_i;
    if (!wr_n && data_oe) mem[addr_o[3:0]] <= data_o;
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the external memory port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic we; logic strb; logic sdram; int wt; logic chk_rd; logic [31:0] exp;
  } emp_note_t;
  logic mclk, arst_n, req_valid, req_we, req_sdram, req_cond_true, flags_mode;
  emp_pkg::emp_width_t req_width;
  logic [23:0] req_addr, addr_o;
  logic [31:0] req_wdata, rdata, data_i, data_o;
  logic req_ready, done, ack_i, addr_oe, data_oe, rd_n, wr_n, sdram_row_strobe_n;
  logic [1:0] bank_select_n, sel_exp;
  logic [3:0] wait_cycles;
  logic flag_chk;
  logic [31:0] shadow [16];
  emp_note_t notes [$];
  emp_note_t n;
  int miscompares, tests_run, rd_cnt, wr_cnt, row_cnt, sel_cnt;

  emp_port emp_port_inst (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
    .req_we(req_we), .req_sdram(req_sdram), .req_cond_true(req_cond_true),
    .req_width(req_width), .req_addr(req_addr), .req_wdata(req_wdata),
    .flags_mode(flags_mode), .req_ready(req_ready), .done(done), .rdata(rdata),
    .ack_i(ack_i), .addr_o(addr_o), .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o),
    .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n), .sdram_row_strobe_n(sdram_row_strobe_n),
    .bank_select_n(bank_select_n));
  emp_mem_model emp_mem_model_inst (.mclk(mclk), .rd_n(rd_n), .wr_n(wr_n), .addr_o(addr_o),
    .addr_oe(addr_oe),
    .data_o(data_o), .data_oe(data_oe), .wait_cycles(wait_cycles), .ack_i(ack_i),
    .data_i(data_i));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (notes.size() != 0) miscompares++;
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One access: note the expectation, present it, wait for completion
  task automatic access(input logic we, input logic sd, input logic cond,
                        input emp_pkg::emp_width_t w, input logic [23:0] a,
                        input logic [31:0] d, input int wt);
    emp_note_t e;
    logic [31:0] m;
    int k;
    m = (w == emp_pkg::EMP_W8) ? 32'h0000_00FF : 32'h0000_FFFF;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(posedge mclk);
      #1;
      k++;
    end
    e.we = we;
    e.strb = cond && !flags_mode;
    e.sdram = sd;
    e.wt = wt;
    e.chk_rd = !we && e.strb;
    e.exp = shadow[a[3:0]] & m;
    if (we && e.strb) shadow[a[3:0]] = d & m;
    notes.push_back(e);
    wait_cycles = 4'(wt);
    {req_valid, req_we, req_sdram, req_cond_true} = {1'b1, we, sd, cond};
    req_width = w;
    req_addr = a;
    req_wdata = d;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    chk("req_ready busy", 32'h0, 32'(req_ready));
    k = 0;
    while (done !== 1'b1 && k < 50) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk("done", 32'h1, 32'(done));
  endtask

  // Pin watcher; takes the oldest note at every done pulse
  always @(negedge mclk) begin
    if (!arst_n) begin
      chk("bus enables in reset", 32'h0, 32'({addr_oe, data_oe}));
    end else begin
      rd_cnt += int'(!rd_n);
      wr_cnt += int'(!wr_n);
      row_cnt += int'(!sdram_row_strobe_n);
      sel_cnt += int'(bank_select_n !== 2'b11);
      sel_exp = addr_oe ? ~(2'b01 << addr_o[22]) : 2'b11;
      chk("bank_select_n", 32'(sel_exp), 32'(bank_select_n));
      if (flag_chk) chk("strobes in flag mode", 32'h3, 32'({rd_n, wr_n}));
      if (done === 1'b1) begin
        if (notes.size() == 0) chk("unexpected done", 32'h0, 32'h1);
        else begin
          n = notes.pop_front();
          chk("rd_n cycles", 32'h0, (n.we || !n.strb) ? 32'(rd_cnt) : 32'h0);
          chk("wr_n cycles", 32'h0, (!n.we || !n.strb) ? 32'(wr_cnt) : 32'h0);
          if (n.strb) chk("strobe length", 32'(2 + n.wt), 32'(rd_cnt + wr_cnt));
          chk("req_ready at done", 32'h1, 32'(req_ready));
          chk("row strobe pulses", 32'(n.sdram), 32'(row_cnt));
          chk("select asserted", 32'h1, 32'(sel_cnt > 0));
          if (n.chk_rd) chk("rdata", n.exp, rdata);
        end
        {rd_cnt, wr_cnt, row_cnt, sel_cnt} = '0;
      end
    end
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #120000;
    chk("watchdog", 32'h0, 32'h1);
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    void'($urandom(32'hF5E7));
    {arst_n, req_valid, req_we, req_sdram, req_cond_true, flags_mode, flag_chk} = '0;
    req_width = emp_pkg::EMP_W8;
    {req_addr, req_wdata, wait_cycles} = '0;
    {miscompares, tests_run, rd_cnt, wr_cnt, row_cnt, sel_cnt} = '0;
    foreach (shadow[i]) shadow[i] = 32'h0;
    repeat (10) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("bus enables after reset", 32'h0, 32'({addr_oe, data_oe}));
    // Fill every word across both banks
    for (int i = 0; i < 16; i++)
      access(1'b1, 1'(i), 1'b1, emp_pkg::EMP_W16, {1'b0, 1'(i >> 1), 18'h0, 4'(i)},
             $urandom, 0);
    // Read back with both widths and stretched strobes
    for (int i = 0; i < 16; i++)
      access(1'b0, 1'(i >> 2), 1'b1, emp_pkg::emp_width_t'(i[0]),
             {1'b0, 1'(i >> 3), 18'h0, 4'(i)}, 32'h0, i % 4);
    // Random mix including false conditions
    repeat (40) begin
      r = $urandom;
      access(r[0], r[1], r[2] | r[3], emp_pkg::emp_width_t'(r[4]),
             {1'b0, r[5], 18'h0, r[9:6]}, $urandom, int'(r[11:10]));
    end
    // Low bus lines as flags: no strobes, write must not land
    flags_mode = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    flag_chk = 1'b1;
    access(1'b1, 1'b0, 1'b1, emp_pkg::EMP_W16, 24'h40_0005, ~shadow[5], 0);
    access(1'b0, 1'b0, 1'b1, emp_pkg::EMP_W16, 24'h40_0005, 32'h0, 0);
    flag_chk = 1'b0;
    flags_mode = 1'b0;
    access(1'b0, 1'b0, 1'b1, emp_pkg::EMP_W16, 24'h40_0005, 32'h0, 0);
    repeat (3) @(posedge mclk);
    give_verdict();
  end
endmodule
